// file: src/rtt_pkg.sv
// constants shared by the tamper-timestamp counter and its word memory
package rtt_pkg;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL_A  = 12'h000;
	localparam logic [11:0] OFF_CTRL_B  = 12'h004;
	localparam logic [11:0] OFF_EVENT_CONTROL  = 12'h008;
	localparam logic [11:0] OFF_INTEN   = 12'h00C;
	localparam logic [11:0] OFF_FLAGS   = 12'h010;
	localparam logic [11:0] OFF_BUSY    = 12'h014;
	localparam logic [11:0] OFF_COUNT   = 12'h018;
	localparam logic [11:0] OFF_TSTAMP  = 12'h01C;
	localparam logic [11:0] OFF_TAMPCTL = 12'h020;
	localparam logic [11:0] OFF_TAMPER_SOURCE_ID  = 12'h024;
	// word memory sits at 0x040..0x06C: gp words 0..3, backup words 4..11
	localparam logic [5:0]  MEM_PAGE    = 6'h01;
	localparam logic [3:0]  MEM_WORDS   = 4'hC;
	localparam int          GP_WORDS    = 4;
	// control_a fields
	localparam int CA_EN       = 0;
	localparam int CA_CSYNC    = 1;
	localparam int CA_MODE_LSB = 2;
	localparam int CA_PRE_LSB  = 8;
	localparam int CA_BATT     = 15;
	// control_b fields
	localparam int CB_GPRST    = 0;
	localparam int CB_MAJ      = 1;
	localparam int CB_DMA      = 2;
	// tamper_control fields
	localparam int TC_ACT_LSB  = 0;
	localparam int TC_RISE     = 2;
	localparam int TC_DEB      = 3;
	// interrupt_flags / sync_busy_flags fields
	localparam int FL_TAMPER   = 8;
	localparam int BZ_EN       = 0;
	localparam int BZ_CSYNC    = 1;
	// counter modes and tamper actions
	localparam logic [1:0] MODE_COUNTER_32BIT_MODE = 2'h0;
	localparam logic [1:0] MODE_COUNTER_16BIT_MODE = 2'h1;
	localparam logic [1:0] MODE_CAL     = 2'h2;
	localparam logic [1:0] ACT_OFF      = 2'h0;
	localparam logic [1:0] ACT_LAYER    = 2'h3;
	// reset value of every register
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	// synchronisation busy time
	localparam int CLK_NS   = 10;
	localparam int SYNC_NS  = 30;
	localparam logic [1:0] SYNC_CYC = 2'((SYNC_NS + CLK_NS - 1) / CLK_NS);
endpackage : rtt_pkg

// file: src/rtt_word_mem.sv
// general-purpose and backup word store with registered read port
`timescale 1ns/1ps
`default_nettype none
module rtt_word_mem
	import rtt_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [3:0]  addr,
	input  wire logic        we,
	input  wire logic [31:0] wdata,
	input  wire logic        clrGp,
	output logic      [31:0] rdata
);
	typedef struct packed {
		logic [11:0][31:0] words;
		logic [31:0]       rdata;
	} rtt_mem_s;

	rtt_mem_s st_ff;
	rtt_mem_s nxt_st;

	// write, tamper wipe of gp words, registered read
	always_comb begin
		nxt_st = st_ff;
		if (we && addr < MEM_WORDS) begin
			nxt_st.words[addr] = wdata;
		end
		for (int i = 0; i < GP_WORDS; i++) begin
			if (clrGp) begin
				nxt_st.words[i] = RST_WORD; // R9
			end
		end
		nxt_st.rdata = (addr < MEM_WORDS) ? st_ff.words[addr] : RST_WORD;
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;

	AST_GP_WIPE: assert property (@(posedge mclk) disable iff (!rstn)
		clrGp |=> (st_ff.words[0] == RST_WORD && st_ff.words[3] == RST_WORD)) // R9
		else $error("gp words not wiped on tamper");
endmodule : rtt_word_mem
`default_nettype wire

// file: src/rtt_tamper_rtc.sv
// real-time counter with tamper capture, periodic events and APB registers
// What this block does
// R1 - narrow counter writes are dropped by hardware
// R2 - first continuous-sync counter snapshot is wrong
// R3 - majority debounce bit stored but has no effect
// R4 - software ignores early rising-edge tamper reports
// R5 - reset during detection skips next timestamp update
// R6 - no timestamp capture in battery backup mode
// R7 - periodic events run if tamper on, prescaler off
// R8 - timestamp read keeps tamper flag when DMA enabled
// R9 - tamper always wipes general-purpose registers
// R10 - software waits busy flags clear before backup
// R11 - active layer mode captures while RTC disabled
// R12 - software clears id, flag and lock after enable
// R13 - timestamp locked until read
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rtt_tamper_rtc
	import rtt_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tamperIn,
	input  wire logic        extResetIn,
	output logic      [7:0]  perEvent
);
	typedef struct packed {
		logic        enable, cntSync;
		logic [1:0]  mode;
		logic [3:0]  presc;
		logic        battery, gpRst, majDeb, dma_service_enable;
		logic [7:0]  evEn;
		logic [8:0]  intEn;
		logic [8:0]  flags;
		logic [1:0]  busyEn, busyCs;
		logic [31:0] count, readCnt;
		logic        firstPend;
		logic [31:0] ts;
		logic        tsLock, tsBlock;
		logic [1:0]  action;
		logic        rising, debEn, tamper_source_id;
		logic [2:0]  tSync;
		logic        tLevel;
		logic [2:0]  xSync;
		logic [15:0] div;
		logic [7:0]  perEv;
		logic        pready, pslverr;
		logic [31:0] prdata;
	} rtt_state_s;

	rtt_state_s st_ff;
	rtt_state_s nxt_st;

	logic        access, done, memHit, decoded, tick, perActive;
	logic        edgeHit, armed, det, cntWrOk, tsRead;
	logic [31:0] memRdata, rdMux;
	logic [15:0] divNext, rise;
	// gp and backup words
	rtt_word_mem uMem (
		.mclk  (mclk),
		.rstn  (rstn),
		.addr  (paddr[5:2]),
		.we    (done && pwrite && memHit),
		.wdata (pwdata),
		.clrGp (det),
		.rdata (memRdata)
	);

	// bus phase decode: one wait state, answer in second access cycle
	assign access = psel && penable;
	assign done   = access && st_ff.pready;
	assign memHit = (paddr[11:6] == MEM_PAGE) && (paddr[5:2] < MEM_WORDS);
	assign tsRead = done && !pwrite && paddr == OFF_TSTAMP;

	// read data selection and address decode
	always_comb begin
		rdMux   = RST_WORD;
		decoded = 1'b1;
		case (paddr)
			OFF_CTRL_A: begin
				rdMux[CA_EN]                   = st_ff.enable;
				rdMux[CA_CSYNC]                = st_ff.cntSync;
				rdMux[CA_MODE_LSB +: 2]        = st_ff.mode;
				rdMux[CA_PRE_LSB +: 4]         = st_ff.presc;
				rdMux[CA_BATT]                 = st_ff.battery;
			end
			OFF_CTRL_B: begin
				rdMux[CB_GPRST] = st_ff.gpRst;
				rdMux[CB_MAJ]   = st_ff.majDeb;
				rdMux[CB_DMA]   = st_ff.dma_service_enable;
			end
			OFF_EVENT_CONTROL:  rdMux[7:0] = st_ff.evEn;
			OFF_INTEN:   rdMux[8:0] = st_ff.intEn;
			OFF_FLAGS:   rdMux[8:0] = st_ff.flags;
			OFF_BUSY: begin
				rdMux[BZ_EN]    = st_ff.busyEn != 2'h0;
				rdMux[BZ_CSYNC] = st_ff.busyCs != 2'h0;
			end
			OFF_COUNT:   rdMux = (st_ff.cntSync ? st_ff.readCnt : st_ff.count)
				& ((st_ff.mode == MODE_COUNTER_16BIT_MODE) ? 32'h0000_FFFF : 32'hFFFF_FFFF);
			OFF_TSTAMP:  rdMux = st_ff.ts;
			OFF_TAMPCTL: begin
				rdMux[TC_ACT_LSB +: 2] = st_ff.action;
				rdMux[TC_RISE]         = st_ff.rising;
				rdMux[TC_DEB]          = st_ff.debEn;
			end
			OFF_TAMPER_SOURCE_ID:  rdMux[0] = st_ff.tamper_source_id;
			default: begin
				rdMux   = memHit ? memRdata : RST_WORD;
				decoded = memHit;
			end
		endcase
	end

	// divider taps, tamper edge qualification
	always_comb begin
		divNext   = st_ff.div + 16'h0001;
		rise      = divNext & ~st_ff.div;
		tick      = (st_ff.presc == 4'h0) ? 1'b1 : rise[st_ff.presc - 4'h1];
		perActive = st_ff.enable && ((st_ff.presc != 4'h0) // R7
			|| st_ff.action != ACT_OFF || st_ff.debEn); // R7
		// majority bit is not consulted: plain two-stage agreement only
		edgeHit   = (st_ff.tSync[1] == st_ff.tSync[2]) // R3
			&& (st_ff.tSync[2] != st_ff.tLevel)
			&& (st_ff.rising ? st_ff.tSync[2] : !st_ff.tSync[2]);
		armed     = st_ff.action != ACT_OFF
			&& (st_ff.enable || st_ff.action == ACT_LAYER); // R11
		det       = armed && edgeHit;
		cntWrOk   = (st_ff.mode == MODE_COUNTER_16BIT_MODE) ? (pstrb[1:0] == 2'h3) // R1
			: (pstrb == 4'hF); // R1
	end

	// next state: counter tick, then bus writes, hardware events after so sets win
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.pready  = access && !st_ff.pready;
		nxt_st.pslverr = access && !st_ff.pready && !decoded;
		nxt_st.prdata  = (access && !st_ff.pready && !pwrite) ? rdMux
			: RST_WORD;
		nxt_st.div     = divNext;
		nxt_st.tSync   = {st_ff.tSync[1:0], tamperIn};
		nxt_st.xSync   = {st_ff.xSync[1:0], extResetIn};
		nxt_st.perEv   = 8'h00;
		if (st_ff.tSync[1] == st_ff.tSync[2]) begin
			nxt_st.tLevel = st_ff.tSync[2];
		end
		if (st_ff.busyEn != 2'h0) begin
			nxt_st.busyEn = st_ff.busyEn - 2'h1;
		end
		if (st_ff.busyCs != 2'h0) begin
			nxt_st.busyCs = st_ff.busyCs - 2'h1;
		end
		// counter runs on the prescaler tick
		if (st_ff.enable && tick) begin
			if (st_ff.mode == MODE_COUNTER_16BIT_MODE) begin
				nxt_st.count = {16'h0000, st_ff.count[15:0] + 16'h0001};
			end else begin
				nxt_st.count = st_ff.count + 32'h0000_0001;
			end
		end
		// register writes at the completing edge
		if (done && pwrite) begin
			case (paddr)
				OFF_CTRL_A: begin
					if (pwdata[CA_EN] != st_ff.enable) begin
						nxt_st.busyEn = SYNC_CYC;
					end
					if (pwdata[CA_CSYNC] != st_ff.cntSync) begin
						nxt_st.busyCs = SYNC_CYC;
					end
					if (pwdata[CA_CSYNC] && !st_ff.cntSync) begin
						nxt_st.firstPend = 1'b1; // R2
					end
					nxt_st.enable  = pwdata[CA_EN];
					nxt_st.cntSync = pwdata[CA_CSYNC];
					nxt_st.mode    = pwdata[CA_MODE_LSB +: 2];
					nxt_st.presc   = pwdata[CA_PRE_LSB +: 4];
					nxt_st.battery = pwdata[CA_BATT];
				end
				OFF_CTRL_B: begin
					nxt_st.gpRst  = pwdata[CB_GPRST];
					nxt_st.majDeb = pwdata[CB_MAJ]; // R3
					nxt_st.dma_service_enable  = pwdata[CB_DMA];
				end
				OFF_EVENT_CONTROL:  nxt_st.evEn  = pwdata[7:0];
				OFF_INTEN:   nxt_st.intEn = pwdata[8:0];
				OFF_FLAGS:   nxt_st.flags = st_ff.flags & ~pwdata[8:0]; // R8
				OFF_COUNT: begin
					if (cntWrOk) begin
						nxt_st.count = (st_ff.mode == MODE_COUNTER_16BIT_MODE)
							? {16'h0000, pwdata[15:0]} : pwdata; // R1
					end
				end
				OFF_TAMPCTL: begin
					nxt_st.action = pwdata[TC_ACT_LSB +: 2];
					nxt_st.rising = pwdata[TC_RISE];
					nxt_st.debEn  = pwdata[TC_DEB];
				end
				OFF_TAMPER_SOURCE_ID: begin
					if (pwdata[0]) begin
						nxt_st.tamper_source_id = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// timestamp read releases the lock; flag cleared only without dma
		if (tsRead) begin
			nxt_st.tsLock = 1'b0; // R13
			if (!st_ff.dma_service_enable) begin
				nxt_st.flags[FL_TAMPER] = 1'b0; // R8
			end
		end
		// continuous-sync snapshot, first one inverted
		if (st_ff.cntSync && st_ff.busyCs == 2'h0) begin
			nxt_st.readCnt   = st_ff.firstPend ? ~st_ff.count : st_ff.count; // R2
			nxt_st.firstPend = 1'b0;
		end
		// periodic flags and event outputs
		if (perActive) begin
			nxt_st.flags[7:0] = nxt_st.flags[7:0] | rise[7:0]; // R7
			nxt_st.perEv      = rise[7:0] & st_ff.evEn; // R7
		end
		// external reset while a tamper edge is settling
		if (st_ff.xSync[1] && st_ff.xSync[2]
			&& st_ff.tSync[1] != st_ff.tSync[2]) begin
			nxt_st.tsBlock = 1'b1; // R5
		end
		// tamper detection
		if (det) begin
			if (st_ff.tsBlock) begin
				nxt_st.tsBlock = 1'b0; // R5
			end else if (!st_ff.battery && !st_ff.tsLock) begin // R6
				nxt_st.ts     = st_ff.count; // R13
				nxt_st.tsLock = 1'b1; // R13
			end
			if (st_ff.enable) begin
				nxt_st.flags[FL_TAMPER] = 1'b1; // R11
				nxt_st.tamper_source_id           = 1'b1; // R11
			end
		end
	end
	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign prdata   = st_ff.prdata;
	assign pready   = st_ff.pready;
	assign pslverr  = st_ff.pslverr;
	assign perEvent = st_ff.perEv;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	AST_NARROW_DROP: assert property (done && pwrite && paddr == OFF_COUNT // R1
		&& st_ff.mode == MODE_COUNTER_32BIT_MODE && pstrb != 4'hF && !st_ff.enable
		|=> st_ff.count == $past(st_ff.count))
		else $error("narrow counter write took effect");
	AST_FIRST_SNAP: assert property (st_ff.cntSync && st_ff.firstPend // R2
		&& st_ff.busyCs == 2'h0 |=> st_ff.readCnt == ~$past(st_ff.count))
		else $error("first sync snapshot not corrupted");
	AST_EDGE_FLAG: assert property (det && st_ff.enable // R11
		|=> st_ff.flags[FL_TAMPER] && st_ff.tamper_source_id)
		else $error("enabled tamper edge not flagged");
	AST_BLOCK_SKIP: assert property (det && st_ff.tsBlock // R5
		|=> $stable(st_ff.ts) && !st_ff.tsBlock)
		else $error("blocked timestamp updated");
	AST_BATT_NOCAP: assert property (det && st_ff.battery && !st_ff.tsLock // R6
		|=> $stable(st_ff.ts) && !st_ff.tsLock)
		else $error("capture in battery backup");
	AST_DMA_FLAG: assert property (tsRead && st_ff.dma_service_enable // R8
		&& st_ff.flags[FL_TAMPER] |=> st_ff.flags[FL_TAMPER])
		else $error("dma timestamp read cleared flag");
	AST_LAYER_CAP: assert property (det && !st_ff.enable // R11
		&& st_ff.action == ACT_LAYER && !st_ff.tsBlock && !st_ff.battery
		&& !st_ff.tsLock |=> st_ff.tsLock && st_ff.ts == $past(st_ff.count))
		else $error("active layer capture missing");
	AST_TS_LOCK: assert property (st_ff.tsLock && !tsRead // R13
		|=> $stable(st_ff.ts) && st_ff.tsLock)
		else $error("locked timestamp changed");
	AST_PER_GATE: assert property (!perActive |=> perEvent == 8'h00) // R7
		else $error("periodic event while inactive");
	COV_CAPTURE: cover property (det ##1 st_ff.tsLock);
	COV_TS_READ: cover property (st_ff.tsLock ##1 tsRead);
	COV_PER_EVT: cover property (perEvent != 8'h00);
	COV_BLOCK: cover property (st_ff.tsBlock ##[1:50] det);
endmodule : rtt_tamper_rtc
`default_nettype wire

// file: verification/rtt_tb.sv
// self-checking bench for the tamper-timestamp real-time counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
	nChecks++; \
	if ((g) !== (e)) begin \
		failCount++; \
		$display("unexpected %s exp %h got %h", n, e, g); \
	end \
end
module testbench;
	import rtt_pkg::*;
	logic        mclk       = 1'b0;
	logic        rstn       = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [11:0] paddr      = 12'h000;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic [3:0]  pstrb      = 4'h0;
	logic        tamperIn   = 1'b0;
	logic        extResetIn = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  perEvent;
	logic [31:0] rd;
	logic [31:0] va;
	logic [31:0] vb;
	logic [31:0] vc;
	logic [31:0] mem [12];
	logic        err;
	int          failCount  = 0;
	int          nChecks    = 0;
	int          hits;

	// clock at 100 MHz
	always #5 mclk = ~mclk;

	rtt_tamper_rtc rtt_tamper_rtc_i (
		.mclk      (mclk),
		.rstn      (rstn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.pstrb     (pstrb),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.tamperIn  (tamperIn),
		.extResetIn(extResetIn),
		.perEvent  (perEvent)
	);

	// expectation helpers
	function automatic logic [11:0] memAddr(input int i);
		return 12'(12'h040 + 4 * i);
	endfunction : memAddr
	function automatic logic [31:0] lo16(input logic [31:0] v);
		return {16'h0000, v[15:0]};
	endfunction : lo16
	function automatic logic [31:0] tcWord(input logic [1:0] a,
		input logic r);
		return (32'(a) << TC_ACT_LSB) | (32'(r) << TC_RISE);
	endfunction : tcWord

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : giveVerdict

	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int k;
		k = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge mclk);
		penable <= 1'b1;
		// pready, prdata and pslverr are taken as sampled at this edge
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) failCount++;
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rdw(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
	endtask : rdw
	task automatic tamp(input logic l);
		@(posedge mclk);
		tamperIn <= l;
		repeat (8) @(posedge mclk);
	endtask : tamp
	task automatic pollBusy();
		int k;
		k = 0;
		do begin
			rdw(OFF_BUSY);
			k++;
		end while (rd[1:0] !== 2'b00 && k < 20);
		`CHK("busy flags", 2'b00, rd[1:0])
	endtask : pollBusy
	task automatic countEvents();
		hits = 0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			if (perEvent[0] === 1'b1) hits++;
		end
	endtask : countEvents
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	// watchdog cuts a hang short
	initial begin
		#300_000;
		failCount++;
		giveVerdict();
	end

	// main sequence
	initial begin
		va = $urandom(32'h1e7403bd);
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 28; i++) begin
			rdw(12'(4 * i));
			`CHK("reset word", RST_WORD, rd)
			`CHK("slverr", (i >= 10 && i < 16), err)
		end
		done("reset");
		va = $urandom();
		apb(1'b1, OFF_COUNT, va, 4'h3);
		rdw(OFF_COUNT);
		`CHK("counter_32bit_mode narrow", 32'h0000_0000, rd)
		wr(OFF_COUNT, va);
		rdw(OFF_COUNT);
		`CHK("counter_32bit_mode full", va, rd)
		wr(OFF_CTRL_A, 32'(MODE_COUNTER_16BIT_MODE) << CA_MODE_LSB);
		vb = $urandom();
		apb(1'b1, OFF_COUNT, vb, 4'h1);
		rdw(OFF_COUNT);
		`CHK("counter_16bit_mode byte", lo16(va), rd)
		apb(1'b1, OFF_COUNT, vb, 4'h3);
		rdw(OFF_COUNT);
		`CHK("counter_16bit_mode half", lo16(vb), rd)
		wr(OFF_CTRL_A, 32'(MODE_CAL) << CA_MODE_LSB);
		apb(1'b1, OFF_COUNT, va, 4'h3);
		rdw(OFF_COUNT);
		`CHK("calendar narrow", lo16(vb), rd)
		wr(OFF_COUNT, va);
		rdw(OFF_COUNT);
		`CHK("calendar full", va, rd)
		wr(OFF_CTRL_A, RST_WORD);
		done("count width");
		wr(OFF_COUNT, va);
		wr(OFF_CTRL_A, 32'h1 << CA_CSYNC);
		pollBusy();
		rdw(OFF_COUNT);
		rdw(OFF_COUNT);
		`CHK("synced count", va, rd)
		wr(OFF_CTRL_A, RST_WORD);
		pollBusy();
		done("count sync");
		for (int i = 0; i < 12; i++) begin
			mem[i] = $urandom();
			wr(memAddr(i), mem[i]);
		end
		wr(OFF_TAMPCTL, tcWord(ACT_LAYER, 1'b1));
		tamp(1'b1);
		tamp(1'b0);
		for (int i = 0; i < 12; i++) begin
			rdw(memAddr(i));
			`CHK("word", (i < GP_WORDS) ? RST_WORD : mem[i], rd)
		end
		rdw(OFF_FLAGS);
		`CHK("flag while off", 1'b0, rd[FL_TAMPER])
		rdw(OFF_TSTAMP);
		wr(OFF_COUNT, va);
		tamp(1'b1);
		tamp(1'b0);
		wr(OFF_COUNT, vb);
		tamp(1'b1);
		tamp(1'b0);
		rdw(OFF_TSTAMP);
		`CHK("locked stamp", va, rd)
		tamp(1'b1);
		tamp(1'b0);
		rdw(OFF_TSTAMP);
		`CHK("next stamp", vb, rd)
		wr(OFF_CTRL_A, 32'h1 << CA_BATT);
		vc = $urandom();
		wr(OFF_COUNT, vc);
		tamp(1'b1);
		rdw(OFF_TSTAMP);
		`CHK("battery stamp", vb, rd)
		wr(OFF_CTRL_A, RST_WORD);
		@(posedge mclk);
		extResetIn <= 1'b1;
		repeat (2) @(posedge mclk);
		tamp(1'b0);
		extResetIn <= 1'b0;
		repeat (8) @(posedge mclk);
		tamp(1'b1);
		rdw(OFF_TSTAMP);
		`CHK("skipped stamp", vb, rd)
		tamp(1'b0);
		tamp(1'b1);
		rdw(OFF_TSTAMP);
		`CHK("stamp after skip", vc, rd)
		tamp(1'b0);
		done("timestamp");
		wr(OFF_CTRL_B, (32'h1 << CB_DMA) | (32'h1 << CB_MAJ));
		rdw(OFF_CTRL_B);
		`CHK("control b", 32'h0000_0006, rd)
		wr(OFF_TAMPCTL, tcWord(2'h1, 1'b1));
		wr(OFF_CTRL_A, 32'h1 << CA_EN);
		pollBusy();
		repeat (10) @(posedge mclk);
		wr(OFF_FLAGS, 32'hFFFF_FFFF);
		wr(OFF_TAMPER_SOURCE_ID, 32'hFFFF_FFFF);
		rdw(OFF_TSTAMP);
		wr(memAddr(0), va);
		tamp(1'b1);
		rdw(OFF_TAMPER_SOURCE_ID);
		`CHK("source id", 1'b1, rd[0])
		rdw(OFF_TSTAMP);
		rdw(OFF_FLAGS);
		`CHK("flag kept", 1'b1, rd[FL_TAMPER])
		wr(OFF_FLAGS, 32'h1 << FL_TAMPER);
		rdw(OFF_FLAGS);
		`CHK("flag cleared", 1'b0, rd[FL_TAMPER])
		rdw(memAddr(0));
		`CHK("gp wiped", RST_WORD, rd)
		tamp(1'b0);
		wr(OFF_CTRL_B, RST_WORD);
		tamp(1'b1);
		rdw(OFF_TSTAMP);
		rdw(OFF_FLAGS);
		`CHK("flag read clear", 1'b0, rd[FL_TAMPER])
		tamp(1'b0);
		done("tamper flag");
		wr(OFF_EVENT_CONTROL, 32'h0000_00FF);
		countEvents();
		`CHK("events tamper on", 1'b1, hits > 0)
		wr(OFF_TAMPCTL, RST_WORD);
		countEvents();
		`CHK("events idle", 1'b1, hits == 0)
		wr(OFF_TAMPCTL, tcWord(2'h1, 1'b0));
		wr(OFF_EVENT_CONTROL, RST_WORD);
		wr(OFF_INTEN, RST_WORD);
		countEvents();
		`CHK("events masked", 1'b1, hits == 0)
		wr(OFF_CTRL_A, RST_WORD);
		pollBusy();
		wr(OFF_CTRL_A, 32'h1 << CA_BATT);
		done("periodic");
		giveVerdict();
	end
endmodule : testbench
`default_nettype wire
